// ### pkg/pmcc_pkg.sv
// package for the program memory cache controller
// assumes one 40 MHz clock and a 32-bit byte address space
`default_nettype none
package pmcc_pkg;
    // ----------------------------------------
    // register map (avalon word addresses x4)
    // ----------------------------------------
    localparam logic [3:0] OFF_MODE   = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MAP    = 4'h8;
    // ----------------------------------------
    // cache mode codes
    // ----------------------------------------
    localparam logic [2:0] MODE_MAPPED = 3'h0;
    localparam logic [2:0] MODE_ENABLE = 3'h2;
    localparam logic [2:0] MODE_FREEZE = 3'h3;
    localparam logic [2:0] MODE_BYPASS = 3'h4;
    localparam logic [2:0] MODE_RESET  = 3'h0;
    // ----------------------------------------
    // address map
    // ----------------------------------------
    localparam logic [31:0] BASE_MAP0  = 32'h0140_0000;
    localparam logic [31:0] BASE_MAP1  = 32'h0000_0000;
    localparam int          EXT_BITS   = 26;
    localparam int          LINE_LSB   = 5;
    localparam int          WORDS_LINE = 8;
    localparam logic [31:0] RD_UNDEF   = 32'hDEAD_BEEF;
endpackage
`default_nettype wire

// ### rtl/pmcc_tag_store.sv
// tag store: one tag plus valid bit per cache line, flip-flop array
// assumes writes and clears are not issued in the same cycle
`default_nettype none
module pmcc_tag_store #(
    parameter int IDX_W = 11,
    parameter int TAG_W = 10
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [IDX_W-1:0] idx,
    input  wire logic             wr_en,
    input  wire logic [TAG_W-1:0] wr_tag,
    input  wire logic             clr_en,
    input  wire logic [IDX_W-1:0] clr_idx,
    output logic      [TAG_W-1:0] rd_tag,
    output logic                  rd_valid
);
    logic [TAG_W-1:0] tag_mem [2**IDX_W];
    logic [2**IDX_W-1:0] valid_reg;
    always_ff @(posedge clk) begin
        if (wr_en) begin
            tag_mem[idx] <= wr_tag;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_reg <= '0;
        end else if (clr_en) begin
            valid_reg[clr_idx] <= 1'b0;
        end else if (wr_en) begin
            valid_reg[idx] <= 1'b1;
        end
    end
    assign rd_tag   = tag_mem[idx];
    assign rd_valid = valid_reg[idx];
endmodule
`default_nettype wire

// ### rtl/pmcc_top.sv
// program memory controller: mapped ram or direct-mapped fetch cache
// assumes fetch, dma and external fetch ports are level request/ack
//
// Contract
// - mapped mode decodes ram; others go external
// - same-block clash stalls dma behind cpu
// - two-block variant lets different blocks overlap
// - cache modes use block 1 as cache
// - cache-range accesses return undefined data
// - direct mapped, 256-bit lines, 2K/4K lines
// - index from bits 15-5 or 16-5
// - tag from bits 25-16 or 25-17
// - separate tag store with valid bit
// - invalidate only on mapped to enabled
// - cpu stalled during invalidate, block0 dma runs
// - miss on tag mismatch or clear valid
// - fill line, set valid, return after eight words
// - reset enters mapped mode
// - cpu always beats dma for ram; in the two-block variant dma to the other block is granted first
// - dma costs cpu one wait, at most every third cycle; two-block dma to the other block costs a pending fetch two
// - cache-range dma completes, writes dropped
// - dma to block 1 deferred during external fetch; in cache modes it completes at once with undefined data
// - stall in one block spares the other
// - mode codes mapped, enable, freeze, bypass
// - miss stalls cpu, fill one word at a time
`default_nettype none
module pmcc_top
    import pmcc_pkg::*;
#(
    parameter bit TWO_BLOCK = 1'b0,
    parameter int IDX_W     = 11,
    parameter int TAG_W     = EXT_BITS - IDX_W - LINE_LSB,
    parameter int B0_BYTES  = 32'h0002_0000
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         map_sel,
    input  wire logic [3:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic      [31:0]  avs_readdata,
    output logic              avs_waitrequest,
    input  wire logic         fetch_req,
    input  wire logic [31:0]  fetch_addr,
    output logic              fetch_ack,
    output logic      [255:0] fetch_data,
    input  wire logic         dma_req,
    input  wire logic         dma_we,
    input  wire logic [31:0]  dma_addr,
    input  wire logic [31:0]  dma_wdata,
    output logic              dma_done,
    output logic      [31:0]  dma_rdata,
    output logic              ext_req,
    output logic      [31:0]  ext_addr,
    input  wire logic         ext_valid,
    input  wire logic [31:0]  ext_data
);
    import pmcc_pkg::*;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int          LINES     = 2**IDX_W;
    localparam logic [31:0] CACHE_B   = 32'(LINES * 32);
    localparam logic [31:0] B0_SIZE   = TWO_BLOCK ? 32'(B0_BYTES) : 32'h0;
    localparam int          RAM_WORDS = (B0_BYTES + LINES * 32) / 4;

    typedef enum logic [1:0] {
        PMCC_IDLE, PMCC_INVAL, PMCC_LOOKUP, PMCC_FILL
    } pmcc_state_e;

    typedef struct packed {
        logic             rs1;
        logic             rs2;
        logic             map1;
        logic             strap_done;
        logic [2:0]       mode;
        pmcc_state_e      st;
        logic [IDX_W-1:0] cnt;
        logic [2:0]       word;
        logic [255:0]     line;
        logic             fack;
        logic             dack;
        logic [31:0]      drd;
        logic             dgap;
        logic             cpu_wait;
        logic             avack;
        logic [31:0]      avrd;
        logic             xreq;
        logic             fill_upd;
        logic [IDX_W:0]   inval_age;
    } pmcc_s;

    pmcc_s r_reg, r_next;
    logic [31:0] ram [RAM_WORDS];
    logic        rst_n;
    assign rst_n = r_reg.rs2;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic [31:0] base, f_off, d_off;
    logic        caching, f_b0, f_b1, d_b0, d_b1, f_int, d_int;
    logic [IDX_W-1:0] f_idx;
    logic [TAG_W-1:0] f_tag, t_tag;
    logic        t_valid, hit, tag_wr;
    always_comb begin
        base    = r_reg.map1 ? BASE_MAP1 : BASE_MAP0;
        caching = r_reg.mode != MODE_MAPPED;
        f_off   = fetch_addr - base;
        d_off   = dma_addr - base;
        f_b0    = f_off < B0_SIZE;
        f_b1    = !f_b0 && f_off < B0_SIZE + CACHE_B;
        d_b0    = d_off < B0_SIZE;
        d_b1    = !d_b0 && d_off < B0_SIZE + CACHE_B;
        f_int   = f_b0 || (f_b1 && !caching);
        d_int   = d_b0 || d_b1;
    end
    assign f_idx = fetch_addr[LINE_LSB +: IDX_W];
    assign f_tag = fetch_addr[LINE_LSB+IDX_W +: TAG_W];
    assign hit   = t_valid && (t_tag == f_tag);

    pmcc_tag_store #(
        .IDX_W (IDX_W),
        .TAG_W (TAG_W)
    ) u_tags (
        .clk      (clk),
        .rst_n    (rst_n),
        .idx      (f_idx),
        .wr_en    (tag_wr),
        .wr_tag   (f_tag),
        .clr_en   (r_reg.st == PMCC_INVAL),
        .clr_idx  (r_reg.cnt),
        .rd_tag   (t_tag),
        .rd_valid (t_valid)
    );
    assign tag_wr = r_reg.st == PMCC_FILL && ext_valid
        && r_reg.word == 3'(WORDS_LINE - 1) && r_reg.fill_upd;

    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    logic cpu_b0, cpu_b1, dma_go, dma_blk;
    logic [31:0] f_word, d_word;
    always_comb begin
        cpu_b0  = fetch_req && f_b0 && r_reg.st != PMCC_INVAL;
        cpu_b1  = (fetch_req && !f_b0) || r_reg.st != PMCC_IDLE;
        // one controller owns block 1 and external fetch
        dma_blk = d_b0 ? cpu_b0 : (TWO_BLOCK ? cpu_b1 : 1'b1);
        if (!TWO_BLOCK) begin
            dma_blk = fetch_req || r_reg.st != PMCC_IDLE;
        end
        dma_go  = dma_req && d_int && !dma_blk && !r_reg.dack
            && !r_reg.dgap;
        f_word  = (f_off >> 2);
        d_word  = (d_off >> 2);
    end

    // ----------------------------------------
    // state update
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.rs1 = 1'b1;
        r_next.rs2 = r_reg.rs1;
        r_next.fack = 1'b0;
        r_next.dack = 1'b0;
        r_next.avack = 1'b0;
        r_next.dgap = r_reg.dack;
        r_next.cpu_wait = dma_go;
        // cycles spent invalidating, watched by the length check
        r_next.inval_age = '0;
        if (r_reg.st == PMCC_INVAL) begin
            r_next.inval_age = r_reg.inval_age + 1'b1;
        end
        if (!r_reg.strap_done) begin
            r_next.strap_done = 1'b1;
            r_next.map1 = map_sel;
        end
        // register bus
        if ((avs_read || avs_write) && !r_reg.avack) begin
            r_next.avack = 1'b1;
            r_next.avrd = 32'h0;
            case (avs_address)
                OFF_MODE:   r_next.avrd = {29'h0, r_reg.mode};
                OFF_STATUS: r_next.avrd = {28'h0, caching,
                    r_reg.st == PMCC_FILL, r_reg.st == PMCC_INVAL,
                    r_reg.map1};
                OFF_MAP:    r_next.avrd = {31'h0, r_reg.map1};
                default:    r_next.avrd = 32'h0;
            endcase
            if (avs_write && avs_address == OFF_MODE) begin
                r_next.mode = avs_writedata[2:0];
                if (r_reg.mode == MODE_MAPPED
                        && avs_writedata[2:0] == MODE_ENABLE) begin
                    r_next.st  = PMCC_INVAL;
                    r_next.cnt = '0;
                end
            end
        end
        // dma port
        if (dma_req && !r_reg.dack && !r_reg.dgap
                && (!d_int || (d_b1 && caching))) begin
            r_next.dack = 1'b1;
            r_next.drd  = RD_UNDEF;
        end else if (dma_go) begin
            r_next.dack = 1'b1;
            r_next.drd  = ram[d_word];
        end
        // fetch port
        case (r_reg.st)
            PMCC_INVAL: begin
                r_next.cnt = r_reg.cnt + 1'b1;
                if (r_reg.cnt == IDX_W'(LINES - 1)) begin
                    r_next.st = PMCC_IDLE;
                end
            end
            PMCC_IDLE: begin
                // a mode write that starts invalidation wins this cycle
                if (fetch_req && !r_reg.fack && !r_reg.cpu_wait
                        && !dma_go && r_next.st == PMCC_IDLE) begin
                    if (f_int) begin
                        r_next.fack = 1'b1;
                        for (int i = 0; i < WORDS_LINE; i++) begin
                            r_next.line[32*i +: 32] =
                                ram[(f_word & ~32'h7) + i];
                        end
                    end else if (f_b1 && caching) begin
                        r_next.fack = 1'b1;
                        r_next.line = {8{RD_UNDEF}};
                    end else if (caching
                            && r_reg.mode != MODE_BYPASS) begin
                        r_next.st = PMCC_LOOKUP;
                    end else begin
                        r_next.st   = PMCC_FILL;
                        r_next.word = '0;
                        r_next.fill_upd = 1'b0;
                        r_next.xreq = 1'b1;
                    end
                end
            end
            PMCC_LOOKUP: begin
                if (hit) begin
                    r_next.fack = 1'b1;
                    r_next.st = PMCC_IDLE;
                    for (int i = 0; i < WORDS_LINE; i++) begin
                        r_next.line[32*i +: 32] =
                            ram[B0_SIZE/4 + 32'(f_idx) * 8 + i];
                    end
                end else begin
                    r_next.st = PMCC_FILL;
                    r_next.word = '0;
                    r_next.xreq = 1'b1;
                    r_next.fill_upd = r_reg.mode == MODE_ENABLE;
                end
            end
            PMCC_FILL: begin
                if (ext_valid) begin
                    r_next.line[32*r_reg.word +: 32] = ext_data;
                    r_next.word = r_reg.word + 1'b1;
                    if (r_reg.word == 3'(WORDS_LINE - 1)) begin
                        r_next.xreq = 1'b0;
                        r_next.fack = 1'b1;
                        r_next.st = PMCC_IDLE;
                    end
                end
            end
            default: r_next.st = PMCC_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers and ram
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
            r_reg.mode <= MODE_RESET;
            r_reg.st <= PMCC_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end
    always_ff @(posedge clk) begin
        if (dma_go && dma_we && !caching || dma_go && dma_we && d_b0) begin
            ram[d_word] <= dma_wdata;
        end
        if (r_reg.st == PMCC_FILL && ext_valid && r_reg.fill_upd) begin
            ram[B0_SIZE/4 + 32'(f_idx) * 8 + 32'(r_reg.word)]
                <= ext_data;
        end
    end

    assign avs_readdata    = r_reg.avrd;
    assign avs_waitrequest = (avs_read || avs_write) && !r_reg.avack;
    assign fetch_ack  = r_reg.fack;
    assign fetch_data = r_reg.line;
    assign dma_done   = r_reg.dack;
    assign dma_rdata  = r_reg.drd;
    assign ext_req    = r_reg.xreq;
    assign ext_addr   = {fetch_addr[31:5], r_reg.word, 2'b00};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_reset_mapped;
        @(posedge clk) $rose(rst_n) |-> r_reg.mode == MODE_MAPPED;
    endproperty
    a_reset_mapped: assert property (p_reset_mapped)
        else $error("not mapped after reset");
    property p_dma_gap;
        @(posedge clk) disable iff (!rst_n) dma_done |=> !dma_done;
    endproperty
    a_dma_gap: assert property (p_dma_gap)
        else $error("dma served back to back");
    property p_inval_stall;
        @(posedge clk) disable iff (!rst_n)
            r_reg.st == PMCC_INVAL |=> !fetch_ack;
    endproperty
    a_inval_stall: assert property (p_inval_stall)
        else $error("fetch acked during invalidate");
    property p_inval_len;
        @(posedge clk) disable iff (!rst_n)
            r_reg.st == PMCC_INVAL
            |-> r_reg.inval_age < {1'b1, {IDX_W{1'b0}}};
    endproperty
    a_inval_len: assert property (p_inval_len)
        else $error("invalidate too long");
    property p_fill_ack;
        @(posedge clk) disable iff (!rst_n)
            tag_wr |=> fetch_ack;
    endproperty
    a_fill_ack: assert property (p_fill_ack)
        else $error("fill not acked");
    property p_xreq_stall;
        @(posedge clk) disable iff (!rst_n) ext_req |-> !fetch_ack;
    endproperty
    a_xreq_stall: assert property (p_xreq_stall)
        else $error("ack during external fetch");
    property p_cpu_first;
        @(posedge clk) disable iff (!rst_n)
            dma_go |-> !fetch_req
                || TWO_BLOCK && (f_b0 != d_b0 || r_reg.st == PMCC_INVAL);
    endproperty
    a_cpu_first: assert property (p_cpu_first)
        else $error("dma granted over cpu");
    property p_hit_ack;
        @(posedge clk) disable iff (!rst_n)
            r_reg.st == PMCC_LOOKUP && hit |=> fetch_ack;
    endproperty
    a_hit_ack: assert property (p_hit_ack)
        else $error("hit not acked next cycle");
endmodule
`default_nettype wire

// ### sim/pmcc_ext_model.sv
// external memory model: eight words per fill request
// assumes ext_req stays high until the eighth word lands
`default_nettype none
module pmcc_ext_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic [31:0] seed,
    input  wire logic        ext_req,
    output logic             ext_valid,
    output logic      [31:0] ext_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    logic       gap;
    initial begin
        cnt = 4'h0;
        gap = 1'b0;
        ext_valid = 1'b0;
        ext_data = 32'h0;
    end
    // idle data flips every cycle so a stale word never matches
    always @(posedge clk) begin
        gap       <= ~gap;
        ext_valid <= 1'b0;
        ext_data  <= ~ext_data;
        if (!ext_req) begin
            cnt <= 4'h0;
        end else if (cnt < 4'h8 && (!slow || gap)) begin
            ext_valid <= 1'b1;
            ext_data  <= seed ^ {28'h0, cnt};
            cnt       <= cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### sim/pmcc_top_test.sv
// bench for the program memory cache controller, one-block variant
// assumes map strap high (base 0) then low, short tag store (IDX_W=4)
`default_nettype none
module pmcc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pmcc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int     IW = 4;
    localparam logic [31:0] A = 32'h0100_0040;
    logic              clk, resetn, rd, wr, wq, fq, fk, dq, dwe, dd;
    logic              er, ev, slow, ms;
    logic [3:0]        aa;
    logic [31:0]       wd, rdat, fa, da, dwd, drd, ea, ed, seed, q;
    logic [255:0]      fdat, p;
    int                num_errors, compares, cyc, n, tf, td;
    bit                x;
    pmcc_top #(.TWO_BLOCK(1'b0), .IDX_W(IW)) dut_u (
        .clk(clk), .resetn(resetn), .map_sel(ms),
        .avs_address(aa), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq),
        .fetch_req(fq), .fetch_addr(fa), .fetch_ack(fk),
        .fetch_data(fdat), .dma_req(dq), .dma_we(dwe), .dma_addr(da),
        .dma_wdata(dwd), .dma_done(dd), .dma_rdata(drd),
        .ext_req(er), .ext_addr(ea), .ext_valid(ev), .ext_data(ed));
    pmcc_ext_model mem_u (.clk(clk), .slow(slow), .seed(seed),
        .ext_req(er), .ext_valid(ev), .ext_data(ed));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [255:0] s, e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %0t seen %0h exp %0h", $time, s, e);
        end
    endtask
    function automatic logic [255:0] pk(input logic [31:0] s);
        for (int i = 0; i < 8; i++)
            pk[32*i +: 32] = s ^ i;
    endfunction
    // read data taken only at the edge waitrequest is low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        rd <= ~w;
        wr <= w;
        aa <= a;
        wd <= d;
        @(posedge clk);
        while (wq !== 1'b0)
            @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // full 32-bit words, one word per transfer
    task automatic dma(input logic w, input logic [31:0] a, d);
        dq  <= 1'b1;
        dwe <= w;
        da  <= a;
        dwd <= d;
        @(posedge clk);
        while (dd !== 1'b1)
            @(posedge clk);
        q = drd;
        dq <= 1'b0;
        @(posedge clk);
    endtask
    task automatic fet(input logic [31:0] a);
        int k;
        fq <= 1'b1;
        fa <= a;
        n = 0;
        k = 0;
        x = 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (er === 1'b1)
                x = 1'b1;
            if (er === 1'b1 && ev === 1'b1) begin
                chk(ea, {a[31:5], k[2:0], 2'b00});
                k++;
            end
        end while (fk !== 1'b1);
        p = fdat;
        fq <= 1'b0;
        @(posedge clk);
    endtask
    // fills carry seed s; a hit must return the packet of seed s
    task automatic fchk(input logic [31:0] a, s, input bit xe);
        seed <= s;
        fet(a);
        chk(x, xe);
        chk(p, pk(s));
        if (!xe)
            chk(n <= 3, 1'b1);
    endtask
    // ----------------------------------------
    // clock, timeout, sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        {resetn, rd, wr, fq, dq, dwe, slow} = 7'h0;
        ms = 1'b1;
        {aa, wd, fa, da, dwd, seed} = 164'h0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, OFF_MODE, 32'h0);
        chk(q[2:0], MODE_RESET);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q[0], 1'b1);
        bus(1'b0, 4'hC, 32'h0);
        chk(q, 32'h0);
        dma(1'b1, 32'h0, 32'h1234_5678);
        dma(1'b0, 32'h0, 32'h0);
        chk(q, 32'h1234_5678);
        fet(32'h0);
        chk(p[31:0], 32'h1234_5678);
        chk(x, 1'b0);
        fchk(32'h0100_0000, 32'h1111_0000, 1'b1);
        // enable from mapped: invalidate stalls the fetch
        bus(1'b1, OFF_MODE, MODE_ENABLE);
        bus(1'b0, OFF_STATUS, 32'h0);
        chk(q[1], 1'b1);
        fchk(A, 32'hA000_0000, 1'b1);
        chk(n >= 2 ** IW, 1'b1);
        fchk(A, 32'hA000_0000, 1'b0);
        slow <= 1'b1;
        fchk(A + 32'h200, 32'hB000_0000, 1'b1);
        slow <= 1'b0;
        fchk(A, 32'hC000_0000, 1'b1);
        bus(1'b1, OFF_MODE, MODE_FREEZE);
        fchk(A + 32'h20, 32'hD000_0000, 1'b1);
        fchk(A + 32'h20, 32'hE000_0000, 1'b1);
        fchk(A, 32'hC000_0000, 1'b0);
        bus(1'b1, OFF_MODE, MODE_BYPASS);
        fchk(A, 32'hF000_0000, 1'b1);
        // back to enable from bypass keeps the lines
        bus(1'b1, OFF_MODE, MODE_ENABLE);
        fchk(A, 32'hC000_0000, 1'b0);
        dma(1'b1, 32'h0, 32'h0000_CAFE);
        dma(1'b0, 32'h0, 32'h0);
        chk(q, RD_UNDEF);
        // same-cycle clash in mapped mode: cpu goes first
        bus(1'b1, OFF_MODE, MODE_MAPPED);
        fq  <= 1'b1;
        fa  <= 32'h20;
        dq  <= 1'b1;
        dwe <= 1'b0;
        da  <= 32'h4;
        tf = 0;
        td = 0;
        for (int i = 1; i < 40; i++) begin
            @(posedge clk);
            if (fk === 1'b1 && tf == 0) begin
                fq <= 1'b0;
                tf = i;
            end
            if (dd === 1'b1 && td == 0) begin
                dq <= 1'b0;
                td = i;
            end
        end
        chk(tf != 0 && tf < td, 1'b1);
        // mid-run reset with the strap low: base moves, mode mapped again
        ms     <= 1'b0;
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, OFF_MAP, 32'h0);
        chk(q[0], 1'b0);
        bus(1'b0, OFF_MODE, 32'h0);
        chk(q[2:0], MODE_MAPPED);
        dma(1'b1, BASE_MAP0 + 32'h24, 32'h5A5A_0001);
        dma(1'b0, BASE_MAP0 + 32'h24, 32'h0);
        chk(q, 32'h5A5A_0001);
        fet(BASE_MAP0 + 32'h20);
        chk(p[63:32], 32'h5A5A_0001);
        chk(x, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
